/* File: design/wdrl_watchdog.sv */
// Watchdog core: reload lock machine, counter, timeout response and register port
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wdrl_watchdog
   import wdrl_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [7:0]        rdata_out,
   input  wire logic              stop_mode_in,
   output logic                   sys_reset_out,
   output logic                   stop_recover_out,
   output logic                   irq_out,
   output logic                   locked_out
);
   logic [7:0]  ctrl;
   logic [7:0]  reload_upper_byte;
   logic [7:0]  reload_high_byte;
   logic [7:0]  reload_low_byte;
   logic [23:0] count;
   logic [7:0]  irq_stat;
   logic [7:0]  irq_mask;
   logic [2:0]  rst_cnt;
   logic        stop_s1;
   logic        stop_s2;
   logic        en_d;
   logic        tick;
   logic        timeout;
   logic        refresh;
   logic        seq_err;
   wdrl_lock_t  lock_st;
   wdrl_lock_t  next_lock_st;

   if (TICK_DIV < 1)
   begin
      $error("wdrl_watchdog: TICK_DIV must be at least 1");
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      hit = wr_in && (a == b);
   endfunction

   // Stop-state level arrives from the power controller domain
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         stop_s1 <= 1'b0;
         stop_s2 <= 1'b0;
      end
      else
      begin
         stop_s1 <= stop_mode_in;
         stop_s2 <= stop_s1;
      end
   end

   wdrl_tick #(.DIV(TICK_DIV)) u_tick
   (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .run_in     (ctrl[CTRL_EN_BIT]),
      .tick_out   (tick)
   );

   // Lock machine
   always_comb
   begin
      next_lock_st = lock_st;
      seq_err      = 1'b0;
      case (lock_st)
         LK_LOCKED:
         begin
            if (hit(addr_in, ADDR_CTRL) && wdata_in == UNLOCK_FIRST)
               next_lock_st = LK_FIRST;
         end
         LK_FIRST:
         begin
            if (wr_in)
            begin
               if (hit(addr_in, ADDR_CTRL) && wdata_in == UNLOCK_SECOND)
                  next_lock_st = LK_UPPER;
               else
               begin
                  next_lock_st = LK_LOCKED;
                  seq_err      = 1'b1;
               end
            end
         end
         LK_UPPER:
         begin
            if (wr_in)
            begin
               next_lock_st = hit(addr_in, ADDR_UPPER) ? LK_HIGH : LK_LOCKED;
               seq_err      = !hit(addr_in, ADDR_UPPER);
            end
         end
         LK_HIGH:
         begin
            if (wr_in)
            begin
               next_lock_st = hit(addr_in, ADDR_HIGH) ? LK_LOW : LK_LOCKED;
               seq_err      = !hit(addr_in, ADDR_HIGH);
            end
         end
         LK_LOW:
         begin
            if (wr_in)
            begin
               next_lock_st = LK_LOCKED;
               seq_err      = !hit(addr_in, ADDR_LOW);
            end
         end
         default:
            next_lock_st = LK_LOCKED;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         lock_st <= LK_LOCKED;
      else
         lock_st <= next_lock_st;
   end

   // Reload bytes written only in their sequence slot
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         reload_upper_byte <= RELOAD_RESET[23:16];
         reload_high_byte  <= RELOAD_RESET[15:8];
         reload_low_byte   <= RELOAD_RESET[7:0];
      end
      else
      begin
         if (lock_st == LK_UPPER && hit(addr_in, ADDR_UPPER))
            reload_upper_byte <= wdata_in;
         if (lock_st == LK_HIGH && hit(addr_in, ADDR_HIGH))
            reload_high_byte <= wdata_in;
         if (lock_st == LK_LOW && hit(addr_in, ADDR_LOW))
            reload_low_byte <= wdata_in;
      end
   end

   // Control register; unlock data never lands here
   // Strobe spelled out: a continuous assignment never sees wr_in read inside hit
   wire ctrl_plain_wr = wr_in && addr_in == ADDR_CTRL
                        && !(lock_st == LK_LOCKED && wdata_in == UNLOCK_FIRST)
                        && !(lock_st == LK_FIRST && wdata_in == UNLOCK_SECOND);

   assign timeout = ctrl[CTRL_EN_BIT] && tick && count == 24'h000000;
   assign refresh = wr_in && addr_in == ADDR_REFRESH;

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         ctrl <= CTRL_RESET;
      else
      begin
         if (ctrl_plain_wr)
         begin
            ctrl[CTRL_EN_BIT]    <= wdata_in[CTRL_EN_BIT];
            ctrl[CTRL_RSTEN_BIT] <= wdata_in[CTRL_RSTEN_BIT];
            if (wdata_in[CTRL_TOF_BIT])
               ctrl[CTRL_TOF_BIT] <= 1'b0;
            if (wdata_in[CTRL_STOP_BIT])
               ctrl[CTRL_STOP_BIT] <= 1'b0;
         end
         if (timeout && ctrl[CTRL_RSTEN_BIT])
         begin
            ctrl[CTRL_TOF_BIT] <= 1'b1;
            if (stop_s2)
               ctrl[CTRL_STOP_BIT] <= 1'b1;
         end
      end
   end

   // Counter
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         en_d  <= 1'b0;
         count <= RELOAD_RESET;
      end
      else
      begin
         en_d <= ctrl[CTRL_EN_BIT];
         if ((ctrl[CTRL_EN_BIT] && !en_d) || refresh || timeout)
            count <= {reload_upper_byte, reload_high_byte, reload_low_byte};
         else if (ctrl[CTRL_EN_BIT] && tick)
            count <= count - 24'h000001;
      end
   end

   // Timeout responses
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         rst_cnt          <= 3'h0;
         stop_recover_out <= 1'b0;
      end
      else
      begin
         stop_recover_out <= timeout && ctrl[CTRL_RSTEN_BIT] && stop_s2;
         if (timeout && ctrl[CTRL_RSTEN_BIT] && !stop_s2)
            rst_cnt <= 3'(RESET_PULSE);
         else if (rst_cnt != 3'h0)
            rst_cnt <= rst_cnt - 3'h1;
      end
   end
   assign sys_reset_out = (rst_cnt != 3'h0);
   assign locked_out    = (lock_st == LK_LOCKED);

   // Interrupts: set wins over write-one clear
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         irq_stat <= 8'h00;
         irq_mask <= IRQ_MASK_RESET;
      end
      else
      begin
         if (hit(addr_in, ADDR_IRQ_MASK))
            irq_mask <= wdata_in;
         irq_stat <= (irq_stat & ~(hit(addr_in, ADDR_IRQ_STAT) ? wdata_in : 8'h00))
                     | ({7'h00, timeout} << IRQ_TIMEOUT_BIT)
                     | ({7'h00, seq_err} << IRQ_SEQERR_BIT);
      end
   end
   assign irq_out = |(irq_stat & irq_mask);

   // Read port
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         rdata_out <= 8'h00;
      else if (rd_in)
      begin
         case (addr_in)
            ADDR_CTRL:     rdata_out <= ctrl;
            ADDR_UPPER:    rdata_out <= reload_upper_byte;
            ADDR_HIGH:     rdata_out <= reload_high_byte;
            ADDR_LOW:      rdata_out <= reload_low_byte;
            ADDR_IRQ_STAT: rdata_out <= irq_stat;
            ADDR_IRQ_MASK: rdata_out <= irq_mask;
            ADDR_COUNT_LO: rdata_out <= count[7:0];
            default:       rdata_out <= 8'h00;
         endcase
      end
      else
         rdata_out <= 8'h00;
   end

   // Assertions
   // Strobe and address written out so that every term is a sampled value
   sequence s_unlock_pair;
      (wr_in && addr_in == ADDR_CTRL && wdata_in == UNLOCK_FIRST && lock_st == LK_LOCKED)
      ##1 (wr_in && addr_in == ADDR_CTRL && wdata_in == UNLOCK_SECOND);
   endsequence

   a_unlock_opens: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_unlock_pair |=> lock_st == LK_UPPER) else $error("unlock pair did not open upper slot");

   a_ctrl_unlock_same: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (wr_in && addr_in == ADDR_CTRL && lock_st == LK_LOCKED && wdata_in == UNLOCK_FIRST && !timeout)
      |=> ctrl == $past(ctrl)) else $error("unlock write changed control");

   a_ctrl_second_same: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (wr_in && addr_in == ADDR_CTRL && lock_st == LK_FIRST && wdata_in == UNLOCK_SECOND && !timeout)
      |=> ctrl == $past(ctrl)) else $error("second unlock write changed control");

   a_order_refuse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (lock_st == LK_UPPER && wr_in && addr_in != ADDR_UPPER)
      |=> lock_st == LK_LOCKED && $stable(reload_high_byte) && $stable(reload_low_byte))
      else $error("out of order reload write accepted");

   a_locked_ignore: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (lock_st == LK_LOCKED && wr_in && addr_in == ADDR_UPPER) |=> $stable(reload_upper_byte))
      else $error("locked upper byte changed");

   a_stray_relock: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (lock_st == LK_HIGH && wr_in && addr_in != ADDR_HIGH) |=> lock_st == LK_LOCKED && irq_stat[IRQ_SEQERR_BIT])
      else $error("stray write did not relock");

   a_low_relock: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (lock_st == LK_LOW && wr_in && addr_in == ADDR_LOW)
      |=> lock_st == LK_LOCKED && reload_low_byte == $past(wdata_in))
      else $error("low byte did not load and relock");

   a_refresh_load: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      refresh |=> count == {reload_upper_byte, reload_high_byte, reload_low_byte})
      else $error("refresh did not reload counter");

   a_normal_reset: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (timeout && ctrl[CTRL_RSTEN_BIT] && !stop_s2) |=> sys_reset_out [*4] ##1 !sys_reset_out)
      else $error("normal timeout reset pulse wrong");

   a_stop_recover: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (timeout && ctrl[CTRL_RSTEN_BIT] && stop_s2) |=> stop_recover_out && !sys_reset_out)
      else $error("stop timeout did not recover");

   a_stop_flags: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (timeout && ctrl[CTRL_RSTEN_BIT] && stop_s2) |=> ctrl[CTRL_TOF_BIT] && ctrl[CTRL_STOP_BIT])
      else $error("stop timeout flags not set");

   a_count_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (ctrl[CTRL_EN_BIT] && en_d && tick && count != 24'h0 && !refresh) |=> count == $past(count) - 24'h1)
      else $error("counter did not step down");
endmodule
`default_nettype wire

/* File: design/wdrl_pkg.sv */
// Package: register map, field positions, reset values and timing for the watchdog block
// Behaviour
// - Timeout in normal run with reset enabled forces system reset, sets timeout flag.
// - Timeout in stop state with reset enabled starts stop recovery instead.
// - Stop-state timeout with reset enabled sets both timeout flag and stop flag in control register.
// - Unlock writes to control address leave control bits unchanged.
// - Reload bytes accepted only in order upper, high, low after unlock.
// - Any other write mid-sequence returns lock machine to locked start.
// - Writes to reload bytes while locked are ignored.
// - Reload value copied into counter on each enable (EN rising) and each refresh.
package wdrl_pkg;
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_UPPER      = 4'h1;
   localparam logic [3:0]  ADDR_HIGH       = 4'h2;
   localparam logic [3:0]  ADDR_LOW        = 4'h3;
   localparam logic [3:0]  ADDR_REFRESH    = 4'h4;
   localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h5;
   localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h6;
   localparam logic [3:0]  ADDR_COUNT_LO   = 4'h7;
   // Control register field positions
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_RSTEN_BIT  = 1;
   localparam int          CTRL_STOP_BIT   = 6;
   localparam int          CTRL_TOF_BIT    = 7;
   localparam logic [7:0]  CTRL_RESET      = 8'h02;
   localparam logic [7:0]  UNLOCK_FIRST    = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND   = 8'hAA;
   localparam logic [23:0] RELOAD_RESET    = 24'h000100;
   localparam logic [7:0]  IRQ_MASK_RESET  = 8'h00;
   // Interrupt status bits
   localparam int          IRQ_TIMEOUT_BIT = 0;
   localparam int          IRQ_SEQERR_BIT  = 1;
   // Watchdog tick period and reset pulse length
   localparam int          SYS_CLK_NS      = 5;
   localparam int          TICK_NS         = 100;
   localparam int          TICK_CYCLES     = (TICK_NS / SYS_CLK_NS < 1) ? 1 : TICK_NS / SYS_CLK_NS;
   localparam int          RESET_PULSE     = 4;

   typedef enum logic [4:0]
   {
      LK_LOCKED = 5'b00001,
      LK_FIRST  = 5'b00010,
      LK_UPPER  = 5'b00100,
      LK_HIGH   = 5'b01000,
      LK_LOW    = 5'b10000
   } wdrl_lock_t;
endpackage

/* File: design/wdrl_tick.sv */
// Tick divider: one-cycle enable pulse every DIV system clocks
`timescale 1ns/1ps
`default_nettype none
module wdrl_tick
   import wdrl_pkg::*;
#(
   parameter int DIV = TICK_CYCLES
)
(
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic run_in,
   output logic      tick_out
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [CW-1:0] cnt;

   if (DIV < 1)
   begin
      $error("wdrl_tick: DIV must be at least 1");
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in || !run_in)
      begin
         cnt      <= '0;
         tick_out <= 1'b0;
      end
      else if (cnt == CW'(DIV - 1))
      begin
         cnt      <= '0;
         tick_out <= 1'b1;
      end
      else
      begin
         cnt      <= cnt + 1'b1;
         tick_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: bench/tb_watchdog_reset_reload_lock.sv */
// Testbench for the watchdog reload lock, counter and timeout response
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_reload_lock;
   import wdrl_pkg::*;
   logic              sys_clk_in;
   logic              reset_in;
   logic [ADDR_W-1:0] addr_in;
   logic [7:0]        wdata_in;
   logic              wr_in;
   logic              rd_in;
   logic [7:0]        rdata_out;
   logic              stop_mode_in;
   logic              sys_reset_out;
   logic              stop_recover_out;
   logic              irq_out;
   logic              locked_out;
   int                num_errors;
   int                n_compared;
   int                i;
   logic [7:0]        v;
   logic [7:0]        n;
   logic              got_rst;
   logic              got_rec;

   wdrl_watchdog #(.TICK_DIV(2)) u_dut
   (
      .sys_clk_in       (sys_clk_in),
      .reset_in         (reset_in),
      .addr_in          (addr_in),
      .wdata_in         (wdata_in),
      .wr_in            (wr_in),
      .rd_in            (rd_in),
      .rdata_out        (rdata_out),
      .stop_mode_in     (stop_mode_in),
      .sys_reset_out    (sys_reset_out),
      .stop_recover_out (stop_recover_out),
      .irq_out          (irq_out),
      .locked_out       (locked_out)
   );

   initial
   begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Counter may have ticked once since its load
   function automatic logic [7:0] near(input logic [7:0] seen, input logic [7:0] ld);
      return {7'h00, (seen === ld) || (seen === ld - 8'h01)};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      wr_in    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
   endtask

   task automatic load(input logic [7:0] lo);
      wr(ADDR_CTRL, UNLOCK_FIRST);
      wr(ADDR_CTRL, UNLOCK_SECOND);
      wr(ADDR_UPPER, 8'h00);
      wr(ADDR_HIGH, 8'h00);
      wr(ADDR_LOW, lo);
   endtask

   task automatic wait_evt(input int lim);
      got_rst = 1'b0;
      got_rec = 1'b0;
      for (i = 0; i < lim && !(got_rst || got_rec); i++)
      begin
         @(posedge sys_clk_in);
         #1;
         got_rst = sys_reset_out;
         got_rec = stop_recover_out;
      end
   endtask

   task automatic conclude;
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #200000;
      num_errors++;
      conclude();
   end

   initial
   begin
      num_errors   = 0;
      n_compared   = 0;
      reset_in     = 1'b1;
      addr_in      = '0;
      wdata_in     = 8'h00;
      wr_in        = 1'b0;
      rd_in        = 1'b0;
      stop_mode_in = 1'b0;
      void'($urandom(26745));
      repeat (16) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rd(ADDR_CTRL, v);
      chk(v, CTRL_RESET);
      chk({7'h00, locked_out}, 8'h01);
      // Stray reload write while locked, then enable
      wr(ADDR_LOW, 8'h33);
      wr(ADDR_CTRL, 8'h03);
      rd(ADDR_COUNT_LO, v);
      chk(near(v, 8'h00), 8'h01);
      wr(ADDR_CTRL, CTRL_RESET);
      // Unlock writes must not touch control bits
      wr(ADDR_CTRL, UNLOCK_FIRST);
      rd(ADDR_CTRL, v);
      chk(v, CTRL_RESET);
      wr(ADDR_CTRL, UNLOCK_SECOND);
      rd(ADDR_CTRL, v);
      chk(v, CTRL_RESET);
      chk({7'h00, locked_out}, 8'h00);
      n = 8'($urandom_range(8, 40));
      wr(ADDR_UPPER, 8'h00);
      wr(ADDR_HIGH, 8'h00);
      wr(ADDR_LOW, n);
      #1 chk({7'h00, locked_out}, 8'h01);
      wr(ADDR_CTRL, 8'h03);
      rd(ADDR_COUNT_LO, v);
      chk(near(v, n), 8'h01);
      // Normal-run timeout
      wait_evt(2 * n + 40);
      chk({7'h00, got_rst}, 8'h01);
      wr(ADDR_REFRESH, 8'h00);
      rd(ADDR_COUNT_LO, v);
      chk(near(v, n), 8'h01);
      rd(ADDR_CTRL, v);
      chk({7'h00, v[CTRL_TOF_BIT]}, 8'h01);
      rd(ADDR_IRQ_STAT, v);
      chk({7'h00, v[IRQ_TIMEOUT_BIT]}, 8'h01);
      // Stop-state timeout
      wr(ADDR_CTRL, 8'h82);
      stop_mode_in <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      wr(ADDR_CTRL, 8'h03);
      wait_evt(2 * n + 40);
      chk({6'h00, got_rec, got_rst}, 8'h02);
      rd(ADDR_CTRL, v);
      chk({6'h00, v[7:6]}, 8'h03);
      wr(ADDR_CTRL, 8'hC2);
      stop_mode_in <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      wr(ADDR_IRQ_STAT, 8'hFF);
      // Sequence broken by an unmapped write
      n = 8'($urandom_range(8, 40));
      load(n);
      wr(ADDR_CTRL, UNLOCK_FIRST);
      wr(ADDR_CTRL, UNLOCK_SECOND);
      wr(ADDR_UPPER, 8'h00);
      wr(4'hF, 8'h5A);
      #1 chk({7'h00, locked_out}, 8'h01);
      wr(ADDR_HIGH, 8'h00);
      wr(ADDR_LOW, 8'h05);
      rd(ADDR_IRQ_STAT, v);
      chk({7'h00, v[IRQ_SEQERR_BIT]}, 8'h01);
      chk({7'h00, irq_out}, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h02);
      #1 chk({7'h00, irq_out}, 8'h01);
      wr(ADDR_IRQ_STAT, 8'h02);
      #1 chk({7'h00, irq_out}, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      rd(ADDR_COUNT_LO, v);
      chk(near(v, n), 8'h01);
      // Reset on timeout off, reload bytes out of order
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, UNLOCK_FIRST);
      wr(ADDR_CTRL, UNLOCK_SECOND);
      wr(ADDR_LOW, 8'h05);
      #1 chk({7'h00, locked_out}, 8'h01);
      wait_evt(2 * n + 40);
      chk({6'h00, got_rec, got_rst}, 8'h00);
      rd(ADDR_CTRL, v);
      chk(v, 8'h01);
      rd(ADDR_IRQ_STAT, v);
      chk(v, 8'h03);
      rd(ADDR_LOW, v);
      chk(v, n);
      rd(4'hE, v);
      chk(v, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
